// >>> core/cst_pkg.sv
// Function
// RULE_01 - Selector 00 filters statically for 16 us, 01 for 64 us.
// RULE_02 - Selector 10 samples at timer A on-time end, 11 at timer B's.
// RULE_03 - Filter register: input three 5:4, two 3:2, one 1:0; 7:6 read zero.
// RULE_04 - Host assigns the chosen timer to a high-side switch for cyclic filters.
// RULE_05 - On-time code 000 stops the timer with its output low.
// RULE_06 - On-time codes 001..101 give 0.1, 0.3, 1.0, 10 and 20 ms.
// RULE_07 - On-time code 110 stops the timer with output high; 111 reserved.
// RULE_08 - Period codes 000..110 give 10, 20, 50, 100, 200 ms, 1 s, 2 s.
// RULE_09 - Timer register: on-time 6:4, period 2:0, bits 7 and 3 read zero.
// RULE_10 - An assigned timer starts by itself once a running on-time is set.
// RULE_11 - Switch clear in restart state also clears the used timer's settings.
// RULE_12 - Cyclic sensing and cyclic wake run together when both are enabled.
// RULE_13 - Wake control bit 7 enables timer B, bit 6 timer A, as wake source.
// RULE_14 - Switch field 010 follows timer A, 011 follows timer B.
// RULE_15 - Output is on for the on-time at each period start; its end samples.
// RULE_16 - All three registers reset to zero: timers stopped low, 16 us filters.
package cst_pkg;
  // Register map and field layout
  localparam logic [6:0] CST_ADDR_FILTER = 7'h09;
  localparam logic [6:0] CST_ADDR_TMR_A  = 7'h0c;
  localparam logic [6:0] CST_ADDR_TMR_B  = 7'h0d;
  localparam logic [7:0] CST_FILTER_MASK = 8'h3f;
  localparam logic [7:0] CST_TMR_MASK    = 8'h77;
  localparam logic [7:0] CST_RESET_VAL   = 8'h00;
  localparam int         CST_ON_LSB      = 4;
  localparam int         CST_PER_LSB     = 0;
  localparam int         CST_WK_EN_A_BIT = 6;
  localparam int         CST_WK_EN_B_BIT = 7;
  // Encodings
  localparam logic [2:0] CST_ON_OFF_LOW  = 3'h0;
  localparam logic [2:0] CST_ON_OFF_HIGH = 3'h6;
  localparam logic [2:0] CST_HS_TMR_A    = 3'h2;
  localparam logic [2:0] CST_HS_TMR_B    = 3'h3;
  localparam logic [2:0] CST_HS_ON       = 3'h1;
  localparam logic [1:0] CST_FLT_STAT16  = 2'h0;
  localparam logic [1:0] CST_FLT_STAT64  = 2'h1;
  localparam logic [1:0] CST_FLT_CYC_A   = 2'h2;
  // Time base: every timer counts whole microseconds
  localparam int CST_CLK_MHZ    = 200;
  localparam int CST_TICK_US    = 1;
  localparam int CST_TICK_CYC   = CST_TICK_US * CST_CLK_MHZ;
  localparam int CST_FLT_SHORT_US = 16;
  localparam int CST_FLT_LONG_US  = 64;
  localparam int CST_CNT_W      = 21;

  typedef struct packed {
    logic       wr;     // Write strobe
    logic       rd;     // Read strobe
    logic [6:0] addr;   // Register address
    logic [7:0] wdata;  // Write data
  } cst_req_s;

  // On-time in microseconds per code; zero for stopped codes
  function automatic logic [CST_CNT_W-1:0] cst_on_us(input logic [2:0] code);
    case (code)
      3'h1:    cst_on_us = 21'd100;
      3'h2:    cst_on_us = 21'd300;
      3'h3:    cst_on_us = 21'd1000;
      3'h4:    cst_on_us = 21'd10000;
      3'h5:    cst_on_us = 21'd20000;
      default: cst_on_us = 21'd0;
    endcase
  endfunction

  // Period in microseconds per code; reserved code falls back to 10 ms
  function automatic logic [CST_CNT_W-1:0] cst_per_us(input logic [2:0] code);
    case (code)
      3'h1:    cst_per_us = 21'd20000;
      3'h2:    cst_per_us = 21'd50000;
      3'h3:    cst_per_us = 21'd100000;
      3'h4:    cst_per_us = 21'd200000;
      3'h5:    cst_per_us = 21'd1000000;
      3'h6:    cst_per_us = 21'd2000000;
      default: cst_per_us = 21'd10000;
    endcase
  endfunction
endpackage

// >>> core/cst_timers.sv
`timescale 1ns/1ps
module cst_timers
  import cst_pkg::*;
#(
  parameter int US_CYCLES = CST_TICK_CYC  // Clock cycles per microsecond tick
) (
  input  wire logic          clk,             // 200 MHz clock
  input  wire logic          sys_rst,         // Power-on / soft reset, sync high
  input  wire cst_req_s      reg_req,         // Register access request
  output logic [7:0]         reg_rdata,       // Read data, one cycle after rd
  input  wire logic [7:0]    wake_ctrl,       // Internal wake control register
  input  wire logic [3:0][2:0] hs_cfg,        // High-side switch config fields
  input  wire logic          restart_state,   // Device is in restart state
  input  wire logic          hs_clear,        // Switch settings cleared pulse
  input  wire logic [2:0]    wake_in,         // wake_input_three..one levels
  output logic [3:0]         high_side_output,// Switch drive levels
  output logic [2:0]         wake_level,      // Filtered wake input levels
  output logic [1:0]         cyclic_wake      // Cyclic wake pulse, B..A
);

  if (US_CYCLES < 1 || US_CYCLES > 255) begin : g_chk
    $error("US_CYCLES out of range");
  end

  typedef struct packed {
    logic [5:0]                  flt_sel;   // Three filter selectors
    logic [1:0][5:0]             tmr_cfg;   // On-time 5:3, period 2:0
    logic [7:0]                  pre;       // Microsecond prescaler
    logic [1:0][CST_CNT_W-1:0]   cnt;       // Timer position in period
    logic [2:0][6:0]             stab;      // Stable-input microseconds
    logic [2:0]                  last_in;
    logic [2:0]                  lvl;
    logic [3:0]                  hs;
    logic [1:0]                  wk;
    logic [7:0]                  rdata;
  } cst_state_s;

  cst_state_s st_q;
  cst_state_s st_d;
  logic       tick;
  logic [1:0] run;
  logic [1:0] tmr_out;
  logic [1:0] on_end;
  logic [1:0] assigned;
  logic [1:0] wake_en;

  assign wake_en = {wake_ctrl[CST_WK_EN_B_BIT], wake_ctrl[CST_WK_EN_A_BIT]}; // [RULE_13]
  assign tick    = (st_q.pre == 8'(US_CYCLES - 1));

  // Timer status decode
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      logic [2:0] on_c;
      on_c = st_q.tmr_cfg[t][5:3];
      assigned[t] = 1'b0;
      for (int h = 0; h < 4; h++) begin
        if (hs_cfg[h] == (t == 0 ? CST_HS_TMR_A : CST_HS_TMR_B)) begin
          assigned[t] = 1'b1;
        end
      end
      // Starts on its own once a running code is set, if assigned to a switch or wake-enabled [RULE_10] [RULE_12]
      run[t] = (cst_on_us(on_c) != '0) && (assigned[t] || wake_en[t]);
      // Stopped codes pin the level [RULE_05] [RULE_07]
      if (on_c == CST_ON_OFF_HIGH) begin
        tmr_out[t] = 1'b1;
      end else begin
        tmr_out[t] = run[t] && (st_q.cnt[t] < cst_on_us(on_c)); // [RULE_15] [RULE_06]
      end
      on_end[t] = run[t] && tick && (st_q.cnt[t] == cst_on_us(on_c) - 21'd1);
    end
  end

  // Next-state logic
  always_comb begin
    st_d = st_q;
    st_d.pre = tick ? 8'h00 : st_q.pre + 8'h01;
    // Register writes keep only defined bits [RULE_03] [RULE_09]
    if (reg_req.wr) begin
      case (reg_req.addr)
        CST_ADDR_FILTER: st_d.flt_sel = reg_req.wdata[5:0];
        CST_ADDR_TMR_A:  st_d.tmr_cfg[0] = {reg_req.wdata[6:4], reg_req.wdata[2:0]};
        CST_ADDR_TMR_B:  st_d.tmr_cfg[1] = {reg_req.wdata[6:4], reg_req.wdata[2:0]};
        default: ;
      endcase
    end
    for (int t = 0; t < 2; t++) begin
      // Clear in restart stops a stale timer misreading switches [RULE_11]
      if (restart_state && hs_clear && assigned[t]) begin
        st_d.tmr_cfg[t] = 6'h00;
      end
      // Counter wraps at the period, on-time sits at its start [RULE_08] [RULE_15]
      if (!run[t]) begin
        st_d.cnt[t] = '0;
      end else if (tick) begin
        if (st_q.cnt[t] >= cst_per_us(st_q.tmr_cfg[t][2:0]) - 21'd1) begin
          st_d.cnt[t] = '0;
        end else begin
          st_d.cnt[t] = st_q.cnt[t] + 21'd1;
        end
      end
      st_d.wk[t] = on_end[t] && wake_en[t]; // [RULE_12] [RULE_13]
    end
    // Wake input filters
    for (int w = 0; w < 3; w++) begin
      logic [1:0] sel;
      sel = st_q.flt_sel[2*w +: 2];
      st_d.last_in[w] = wake_in[w];
      if (wake_in[w] != st_q.last_in[w]) begin
        st_d.stab[w] = 7'h00;
      end else if (tick && st_q.stab[w] != 7'(CST_FLT_LONG_US)) begin
        st_d.stab[w] = st_q.stab[w] + 7'h01;
      end
      case (sel)
        CST_FLT_STAT16: if (st_q.stab[w] >= 7'(CST_FLT_SHORT_US)) st_d.lvl[w] = st_q.last_in[w]; // [RULE_01]
        CST_FLT_STAT64: if (st_q.stab[w] >= 7'(CST_FLT_LONG_US)) st_d.lvl[w] = st_q.last_in[w]; // [RULE_01]
        default: begin
          // Sample only at the chosen timer's on-time end [RULE_02] [RULE_15]
          if (on_end[sel == CST_FLT_CYC_A ? 0 : 1] && st_q.stab[w] >= 7'(CST_FLT_SHORT_US)) begin
            st_d.lvl[w] = st_q.last_in[w];
          end
        end
      endcase
    end
    // Switch routing [RULE_14]
    for (int h = 0; h < 4; h++) begin
      case (hs_cfg[h])
        CST_HS_ON:    st_d.hs[h] = 1'b1;
        CST_HS_TMR_A: st_d.hs[h] = tmr_out[0];
        CST_HS_TMR_B: st_d.hs[h] = tmr_out[1];
        default:      st_d.hs[h] = 1'b0;
      endcase
    end
    // Read path; reserved bits and unmapped addresses read zero [RULE_03] [RULE_09]
    if (reg_req.rd) begin
      case (reg_req.addr)
        CST_ADDR_FILTER: st_d.rdata = {2'b00, st_q.flt_sel};
        CST_ADDR_TMR_A:  st_d.rdata = {1'b0, st_q.tmr_cfg[0][5:3], 1'b0, st_q.tmr_cfg[0][2:0]};
        CST_ADDR_TMR_B:  st_d.rdata = {1'b0, st_q.tmr_cfg[1][5:3], 1'b0, st_q.tmr_cfg[1][2:0]};
        default:         st_d.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset leaves timers stopped and filters at 16 us [RULE_16]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata        = st_q.rdata;
  assign high_side_output = st_q.hs;
  assign wake_level       = st_q.lvl;
  assign cyclic_wake      = st_q.wk;

  a_rsv_filter_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_03]
    reg_req.rd && reg_req.addr == CST_ADDR_FILTER |=> reg_rdata[7:6] == 2'b00)
    else $error("filter reserved bits not zero");
  a_tmr_write_mask: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_09]
    reg_req.wr && reg_req.addr == CST_ADDR_TMR_A && !(restart_state && hs_clear)
    |=> st_q.tmr_cfg[0] == {$past(reg_req.wdata[6:4]), $past(reg_req.wdata[2:0])})
    else $error("timer A write not stored");
  a_off_low_out: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_05]
    st_q.tmr_cfg[0][5:3] == CST_ON_OFF_LOW |-> !tmr_out[0] && !on_end[0])
    else $error("stopped timer drives high");
  a_hold_high_out: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_07]
    st_q.tmr_cfg[1][5:3] == CST_ON_OFF_HIGH |-> tmr_out[1] && !run[1] && !on_end[1])
    else $error("held-high timer not high");
  a_hs_route_a: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_14]
    hs_cfg[0] == CST_HS_TMR_A |=> high_side_output[0] == $past(tmr_out[0]))
    else $error("switch does not follow timer A");
  a_restart_clear: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_11]
    restart_state && hs_clear && assigned != 2'b00
    |=> (!$past(assigned[0]) || st_q.tmr_cfg[0] == 6'h00)
        && (!$past(assigned[1]) || st_q.tmr_cfg[1] == 6'h00))
    else $error("restart clear missed");
  a_wake_src_gate: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_13]
    cyclic_wake[0] |-> $past(wake_ctrl[CST_WK_EN_A_BIT]) && $past(on_end[0]))
    else $error("cyclic wake without enable");
  a_period_start: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_15]
    run[0] && st_q.cnt[0] == '0 |-> tmr_out[0])
    else $error("on-time not at period start");
  a_auto_start: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_10]
    run[1] && tick && st_q.cnt[1] == '0 |=> st_q.cnt[1] == 21'd1)
    else $error("timer did not start");
  a_reset_zero: assert property (@(posedge clk) // [RULE_16]
    sys_rst |=> st_q.flt_sel == 6'h00 && st_q.tmr_cfg == '0 && high_side_output == 4'h0)
    else $error("registers not zero after reset");
  a_static_short: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_01]
    st_q.flt_sel[1:0] == CST_FLT_STAT16 && st_q.stab[0] < 7'(CST_FLT_SHORT_US)
    |=> $stable(wake_level[0]))
    else $error("static filter passed short pulse");
endmodule

// >>> testbench/cst_host.sv
`timescale 1ns/1ps
// Host model: issues register strobes and routes timers to switches
module cst_host
  import cst_pkg::*;
(
  input  wire logic       clk,     // Bench clock
  output cst_req_s        reg_req, // Register request to the block
  output logic [3:0][2:0] hs_cfg   // Switch configuration fields
);
  initial begin
    reg_req = '0;
    hs_cfg  = '0;
  end

  // One-cycle strobe; idle lines carry inverted values so stale data never matches
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // A timer is tied to a switch before its on-time is set
  task automatic assign_hs(input int i, input logic [2:0] c);
    @(posedge clk);
    hs_cfg[i] <= c;
  endtask
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb
  import cst_pkg::*;
;
  localparam int US = 1; // One cycle per microsecond keeps the run short
  logic clk, sys_rst, restart_state, hs_clear, rd_seen, hs_prev;
  logic [7:0] wake_ctrl, reg_rdata, d;
  logic [2:0] wake_in, wake_level;
  logic [3:0] high_side_output;
  logic [1:0] cyclic_wake;
  logic [8:0] obs;
  logic [3:0][2:0] hs_cfg;
  cst_req_s reg_req;
  int failures, check_count, hi_cnt, per_cnt, n, n2;
  logic [7:0] exp_rd[$];
  int exp_w[$], exp_p[$];
  logic [6:0] addrs[4] = '{7'h09, 7'h0c, 7'h0d, 7'h0a};
  logic [7:0] masks[4] = '{8'h3f, 8'h77, 8'h77, 8'h00};
  int on_us[4] = '{0, 100, 300, 1000};

  assign obs = {wake_level, cyclic_wake, high_side_output};

  cst_host i_cst_host (.clk(clk), .reg_req(reg_req), .hs_cfg(hs_cfg));
  cst_timers #(.US_CYCLES(US)) i_cst_timers (
    .clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .wake_ctrl(wake_ctrl), .hs_cfg(hs_cfg), .restart_state(restart_state),
    .hs_clear(hs_clear), .wake_in(wake_in), .high_side_output(high_side_output),
    .wake_level(wake_level), .cyclic_wake(cyclic_wake));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Bounded wait on one observed output bit; running out counts as a mismatch
  task automatic wait_sig(input int s, input logic v, input int lim, output int c);
    c = 0;
    while (obs[s] !== v) begin
      if (c == lim) begin
        failures++;
        wrap_up();
      end
      tick(1);
      c++;
    end
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    i_cst_host.acc(1'b0, a, 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Watcher: read data one cycle after the strobe, pulse widths and periods on switch 0
  always @(posedge clk) begin
    rd_seen <= reg_req.rd === 1'b1;
    hs_prev <= high_side_output[0];
    hi_cnt  <= high_side_output[0] ? hi_cnt + 1 : 0;
    per_cnt <= (high_side_output[0] && !hs_prev) ? 1 : per_cnt + 1;
    if (rd_seen) cmp(reg_rdata, exp_rd.pop_front());
    if (!high_side_output[0] && hs_prev && exp_w.size() > 0)
      cmp(hi_cnt, exp_w.pop_front());
    if (high_side_output[0] && !hs_prev && exp_p.size() > 0)
      cmp(per_cnt, exp_p.pop_front());
  end

  initial begin
    sys_rst = 1'b1;
    {restart_state, hs_clear, wake_ctrl, wake_in} = '0;
    void'($urandom(32'he3575add));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    tick(1);
    cmp(obs, 9'h000);
    foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
    // Random writes: reserved bits drop, the unmapped place reads zero
    foreach (addrs[i]) begin
      d = 8'($urandom);
      i_cst_host.acc(1'b1, addrs[i], d);
      rd_chk(addrs[i], d & masks[i]);
      i_cst_host.acc(1'b1, addrs[i], 8'h00);
    end
    // Static filters: input one 16 us, input two 64 us
    i_cst_host.acc(1'b1, 7'h09, 8'h04);
    @(posedge clk);
    wake_in <= 3'b011;
    wait_sig(6, 1'b1, 40, n);
    wait_sig(7, 1'b1, 90, n2);
    cmp(n inside {[15:18]}, 1'b1);
    cmp((n + n2) inside {[62:67]}, 1'b1);
    // Stopped codes hold switch 1 through timer B
    i_cst_host.assign_hs(1, 3'h3);
    i_cst_host.acc(1'b1, 7'h0d, 8'h60);
    wait_sig(1, 1'b1, 8, n);
    tick(300);
    cmp(obs[1], 1'b1);
    i_cst_host.acc(1'b1, 7'h0d, 8'h00);
    wait_sig(1, 1'b0, 8, n);
    // On-time widths of timer A on switch 0, started by the write alone
    i_cst_host.assign_hs(0, 3'h2);
    for (int k = 1; k <= 3; k++) begin
      exp_w.push_back(on_us[k] * US);
      i_cst_host.acc(1'b1, 7'h0c, {1'b0, 3'(k), 4'h0});
      wait_sig(0, 1'b1, 8, n);
      wait_sig(0, 1'b0, 1100, n);
      i_cst_host.acc(1'b1, 7'h0c, 8'h00);
    end
    // Period of 10 ms, rise to rise
    i_cst_host.acc(1'b1, 7'h0c, 8'h10);
    wait_sig(0, 1'b1, 8, n);
    // Noted only after the first rise, so that rise is not measured
    wait_sig(0, 1'b0, 200, n);
    exp_p.push_back(10000 * US);
    wait_sig(0, 1'b1, 10100, n);
    // Cyclic filters: three on timer A, one on idle timer B; timer A wakes
    i_cst_host.acc(1'b1, 7'h09, 8'h27);
    @(posedge clk);
    wake_ctrl <= 8'h40;
    wake_in <= 3'b000;
    wait_sig(4, 1'b1, 10200, n);
    @(posedge clk);
    wake_in <= 3'b100;
    tick(200);
    cmp(obs[8], 1'b0);
    wait_sig(4, 1'b1, 10200, n);
    tick(3);
    cmp(obs[8:4], 5'b10100);
    // Timer B, still routed to switch 1, runs as the wake source and samples input one
    @(posedge clk);
    wake_ctrl <= 8'h80;
    i_cst_host.acc(1'b1, 7'h0d, 8'h10);
    wait_sig(5, 1'b1, 300, n);
    tick(3);
    cmp(obs[8:4], 5'b10000);
    // Restart clear drops only the routed timer's settings
    i_cst_host.assign_hs(1, 3'h0);
    i_cst_host.acc(1'b1, 7'h0d, 8'h25);
    @(posedge clk);
    {restart_state, hs_clear} <= 2'b11;
    @(posedge clk);
    hs_clear <= 1'b0;
    rd_chk(7'h0c, 8'h00);
    rd_chk(7'h0d, 8'h25);
    tick(3);
    wrap_up();
  end
endmodule
